// File: common/wdt_sleep_defs.vh
/*
 * watchdog / sleep control constants: register offsets, field positions,
 * reset values and timing counts. assumes a 50 mhz system clock.
 */
`ifndef WDT_SLEEP_DEFS_VH
`define WDT_SLEEP_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_OPTION      14'h0081
`define OFS_OPTION_HI   14'h0181
`define OFS_FUSE        14'h2007
`define OFS_STATUS      14'h0003
`define OFS_USERID0     14'h2000
`define OFS_PROGMODE    14'h0300
`define OFS_ERASE       14'h0301
`define OFS_PROG_DATA   14'h0302

// ****************************************************************
// field positions
// ****************************************************************
`define OPT_PSA         3
`define FUSE_WATCHDOG_ENABLE_FUSE       2
`define FUSE_CP_N       0
`define FUSE_CPD_N      1
`define ST_TO_N         4
`define ST_PD_N         3

// ****************************************************************
// reset values
// ****************************************************************
`define OPTION_RST      8'hff
`define FUSE_RST        8'hff

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ          50000000
`define WDT_PERIOD_US   18000
`define WDT_CYCLES      ((`CLK_HZ / 1000000) * `WDT_PERIOD_US)
`define OST_PERIODS     1024

`endif

// File: logic/wdt_sleep_ctrl.v
/*
 * watchdog timer with postscaler, sleep entry / wake control, reset
 * cause flags, code-protected program read-out and user id words.
 * assumes: core drives one-cycle op strobes; rc clock arrives as a
 * synchronous tick input; register port from a simple strobe master.
 * master clear and irq levels are already synchronous to clk;
 * clk_en low freezes every register of the block except the reset synchroniser.
 */
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`include "wdt_sleep_defs.vh"

module wdt_sleep_ctrl #(
    parameter [31:0] WDT_CYCLES = `WDT_CYCLES
) (
    // clock, reset, enable
    input  wire        clk,
    input  wire        rst_b,
    input  wire        clk_en,
    // watchdog rc oscillator tick, one cycle per rc edge
    input  wire        rc_tick,
    // core operations
    input  wire        watchdog_clear_op,
    input  wire        sleep_op,
    input  wire        master_clear_pin,
    input  wire        global_irq_enable,
    input  wire        irq_enable_any,
    input  wire        irq_pending_any,
    input  wire        xtal_mode,
    input  wire        osc_tick,
    // pin drive state from the port logic
    input  wire [7:0]  pin_out_in,
    input  wire [7:0]  pin_oe_in,
    // program memory read path
    input  wire [13:0] prog_rdata_in,
    // register port
    input  wire [13:0] addr,
    input  wire [13:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [13:0] rdata,
    // core control
    output reg         device_reset,
    output reg         asleep,
    output reg         osc_drive_en,
    output reg         core_hold,
    output reg         prefetch_next,
    output reg         vector_after_wake,
    output reg         sleep_as_nop,
    output reg         bulk_erase,
    output reg  [7:0]  pin_out,
    output reg  [7:0]  pin_oe,
    output reg         master_clear_drive,
    output reg         timeout_flag_n,
    output reg         powerdown_flag_n
);

// ****************************************************************
// functions
// ****************************************************************
function [7:0] ps_ratio_mask;
    input [2:0] sel;
    begin
        ps_ratio_mask = (8'h01 << sel) - 8'h01;
    end
endfunction

// ****************************************************************
// reset synchroniser
// ****************************************************************
reg rst_s1_r;
reg rst_s2_r;
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rst_s1_r <= 1'b0;
        rst_s2_r <= 1'b0;
    end else begin
        rst_s1_r <= 1'b1;
        rst_s2_r <= rst_s1_r;
    end
end
wire rst_n = rst_s2_r;

// ****************************************************************
// state
// ****************************************************************
localparam [3:0] ST_RUN   = 4'h1;
localparam [3:0] ST_SLEEP = 4'h2;
localparam [3:0] ST_OST   = 4'h4;
localparam [3:0] ST_NEXT  = 4'h8;

reg [3:0]  state_r;
reg [3:0]  state_nxt;
reg [7:0]  option_r;
reg [7:0]  fuse_r;
reg        prog_mode_r;
reg [13:0] user_id_r [0:3];
reg [31:0] wdt_cnt_r;
reg [7:0]  post_cnt_r;
reg [10:0] ost_cnt_r;
reg        irq_wake_r;

wire wdt_on   = fuse_r[`FUSE_WATCHDOG_ENABLE_FUSE];
wire prescaler_assign      = option_r[`OPT_PSA];
wire base_exp = rc_tick && (wdt_cnt_r >= WDT_CYCLES - 32'd1);
wire post_exp = !prescaler_assign || (post_cnt_r == ps_ratio_mask(option_r[2:0]));
wire wdt_exp  = wdt_on && base_exp && post_exp;
wire irq_wake = irq_enable_any && irq_pending_any;
wire nop_slp  = irq_wake && !global_irq_enable;
wire slp_go   = sleep_op && !nop_slp && state_r == ST_RUN;
wire wake     = state_r == ST_SLEEP && (wdt_exp || irq_wake);
// external reset pulls the core out of sleep straight to run
wire master_clear_pin_wake = master_clear_pin && state_r == ST_SLEEP;
wire wdt_clr  = watchdog_clear_op || slp_go || wake;
wire wr_en    = wr && clk_en;
wire in_prog  = (addr & 14'h3ffc) == `OFS_USERID0;
wire ost_done = osc_tick && ost_cnt_r == `OST_PERIODS - 1;

// ****************************************************************
// sleep state machine
// ****************************************************************
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_RUN:   if (slp_go) state_nxt = ST_SLEEP;
        ST_SLEEP: if (wake) state_nxt = xtal_mode ? ST_OST : ST_NEXT;
        ST_OST:   if (ost_done) state_nxt = ST_NEXT;
        ST_NEXT:  state_nxt = ST_RUN;
        default:  state_nxt = ST_RUN;
    endcase
    if (master_clear_pin_wake)
        state_nxt = ST_RUN;
end

// ****************************************************************
// watchdog base counter, counts rc ticks
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        wdt_cnt_r <= 32'h0;
    end else if (clk_en) begin
        if (wdt_clr || !wdt_on || base_exp)
            wdt_cnt_r <= 32'h0;
        else if (rc_tick)
            wdt_cnt_r <= wdt_cnt_r + 32'h1;
    end
end

// ****************************************************************
// postscaler, counts base expiries
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        post_cnt_r <= 8'h00;
    end else if (clk_en) begin
        // postscaler idles while unassigned
        if (wdt_clr || wdt_exp || !wdt_on || !prescaler_assign)
            post_cnt_r <= 8'h00;
        else if (base_exp)
            post_cnt_r <= post_cnt_r + 8'h01;
    end
end

// ****************************************************************
// sleep state register
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_RUN;
    end else if (clk_en) begin
        state_r <= state_nxt;
    end
end

// ****************************************************************
// core control outputs
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        device_reset       <= 1'b0;
        asleep             <= 1'b0;
        osc_drive_en       <= 1'b1;
        core_hold          <= 1'b0;
        prefetch_next      <= 1'b0;
        vector_after_wake  <= 1'b0;
        sleep_as_nop       <= 1'b0;
        master_clear_drive <= 1'b0;
    end else if (clk_en) begin
        master_clear_drive <= 1'b0;
        prefetch_next      <= slp_go;
        sleep_as_nop       <= sleep_op && nop_slp
                              && state_r == ST_RUN;
        device_reset       <= (wdt_exp && state_r != ST_SLEEP)
                              || master_clear_pin;
        asleep             <= state_nxt == ST_SLEEP;
        osc_drive_en       <= state_nxt != ST_SLEEP;
        core_hold          <= state_nxt == ST_SLEEP
                              || state_nxt == ST_OST;
        vector_after_wake  <= state_r == ST_NEXT && irq_wake_r
                              && global_irq_enable;
    end
end

// ****************************************************************
// pin drive hold while asleep
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pin_out <= 8'h00;
        pin_oe  <= 8'h00;
    end else if (clk_en) begin
        // frozen copy keeps the pre-sleep drive
        if (state_r != ST_SLEEP) begin
            pin_out <= pin_out_in;
            pin_oe  <= pin_oe_in;
        end
    end
end

// ****************************************************************
// oscillator start-up wait
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ost_cnt_r <= 11'h000;
    end else if (clk_en) begin
        // only crystal modes ever enter the wait
        if (state_r != ST_OST)
            ost_cnt_r <= 11'h000;
        else if (osc_tick)
            ost_cnt_r <= ost_cnt_r + 11'h001;
    end
end

// ****************************************************************
// wake source memory
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        irq_wake_r <= 1'b0;
    end else if (clk_en) begin
        if (wake)
            irq_wake_r <= irq_wake;
    end
end

// ****************************************************************
// reset cause flags
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b1;
    end else if (clk_en) begin
        if (slp_go) begin
            powerdown_flag_n <= 1'b0;
            timeout_flag_n   <= 1'b1;
        end else if (watchdog_clear_op) begin
            powerdown_flag_n <= 1'b1;
            timeout_flag_n   <= 1'b1;
        end
        // expiry and clear in one cycle: expiry wins
        if (wdt_exp)
            timeout_flag_n <= 1'b0;
    end
end

// ****************************************************************
// option register
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        option_r <= `OPTION_RST;
    end else if (wr_en) begin
        // both bank images reach one register
        if (addr == `OFS_OPTION || addr == `OFS_OPTION_HI)
            option_r <= wdata[7:0];
    end
end

// ****************************************************************
// program mode, fuse word and bulk erase
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        prog_mode_r <= 1'b0;
        fuse_r      <= `FUSE_RST;
        bulk_erase  <= 1'b0;
    end else if (clk_en) begin
        bulk_erase <= 1'b0;
        if (wr_en && addr == `OFS_PROGMODE)
            prog_mode_r <= wdata[0];
        if (wr_en && prog_mode_r && addr == `OFS_FUSE)
            fuse_r <= fuse_r & wdata[7:0];
        if (wr_en && prog_mode_r && addr == `OFS_ERASE && wdata[0]) begin
            fuse_r     <= `FUSE_RST;
            bulk_erase <= 1'b1;
        end
    end
end

// ****************************************************************
// user id words, program mode only
// ****************************************************************
integer i;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        for (i = 0; i < 4; i = i + 1)
            user_id_r[i] <= 14'h0000;
    end else if (wr_en && prog_mode_r && in_prog) begin
        user_id_r[addr[1:0]] <= wdata;
    end
end

// ****************************************************************
// read port, data one cycle after strobe
// ****************************************************************
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rdata <= 14'h0000;
    end else if (clk_en) begin
        rdata <= 14'h0000;
        if (rd) begin
            case (addr)
                `OFS_OPTION, `OFS_OPTION_HI:
                    rdata <= {6'h00, option_r};
                `OFS_FUSE:
                    rdata <= {6'h00, fuse_r};
                `OFS_STATUS:
                    rdata <= {9'h000, timeout_flag_n, powerdown_flag_n,
                              3'h0};
                `OFS_PROGMODE:
                    rdata <= {13'h0000, prog_mode_r};
                `OFS_PROG_DATA:
                    rdata <= fuse_r[`FUSE_CP_N] ? prog_rdata_in
                                                 : 14'h0000;
                default:
                    if (in_prog && prog_mode_r)
                        rdata <= user_id_r[addr[1:0]];
            endcase
        end
    end
end

endmodule // wdt_sleep_ctrl

// File: verif/wdt_sleep_ctrl_monitor.sv
/* checker for wdt_sleep_ctrl: sleep entry, wake paths, pin hold, flags.
   assumes a bind to the top module ports and one clock domain. */
`timescale 1ns/100ps
module wdt_sleep_ctrl_monitor (
    // clock, reset and core side
    input wire logic       clk, rst_b, clk_en, sleep_op, master_clear_pin,
    input wire logic       global_irq_enable, irq_enable_any, irq_pending_any,
    // outputs watched
    input wire logic       device_reset, asleep, osc_drive_en, prefetch_next,
    input wire logic       vector_after_wake, sleep_as_nop, master_clear_drive,
    input wire logic       timeout_flag_n, powerdown_flag_n,
    input wire logic [7:0] pin_out, pin_oe
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire irq_on = irq_enable_any && irq_pending_any;
    wire sleep_go = sleep_op && clk_en && !asleep && !irq_on && !device_reset;
    property p_no_master_clear_pin; !master_clear_drive; endproperty
    a_no_master_clear_pin: assert property (p_no_master_clear_pin)
        else $error("master clear pin driven");
    property p_sleep_in;
        sleep_go |=> asleep && !powerdown_flag_n && timeout_flag_n
            && !osc_drive_en;
    endproperty
    a_sleep_in: assert property (p_sleep_in)
        else $error("sleep entry state wrong");
    property p_prefetch; sleep_go |=> prefetch_next; endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("no prefetch after sleep");
    property p_nop;
        sleep_op && clk_en && !asleep && irq_on && !global_irq_enable
            |=> sleep_as_nop && !asleep;
    endproperty
    a_nop: assert property (p_nop)
        else $error("sleep not turned into nop");
    property p_pin_hold;
        asleep ##1 asleep |-> $stable(pin_out) && $stable(pin_oe);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("pins moved while asleep");
    property p_irq_wake; asleep && irq_on |-> ##[1:4] !asleep; endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("enabled irq did not wake");
    property p_vector;
        asleep && irq_on && global_irq_enable |-> ##[1:8] vector_after_wake;
    endproperty
    a_vector: assert property (p_vector)
        else $error("no vector after irq wake");
    property p_no_vector;
        asleep && irq_on && !global_irq_enable |=> (!vector_after_wake)[*4];
    endproperty
    a_no_vector: assert property (p_no_vector)
        else $error("vector taken with gie clear");
    property p_asleep_rst; asleep && !master_clear_pin |-> !device_reset;
    endproperty
    a_asleep_rst: assert property (p_asleep_rst)
        else $error("reset while asleep");
    property p_to_flag;
        device_reset && !$past(master_clear_pin) |-> ##[0:2] !timeout_flag_n;
    endproperty
    a_to_flag: assert property (p_to_flag)
        else $error("timeout flag not cleared on expiry");
    property p_pd_wake; $fell(asleep) |-> !powerdown_flag_n; endproperty
    a_pd_wake: assert property (p_pd_wake)
        else $error("power-down flag set on wake");
    c_sleep: cover property (sleep_go);
    c_reset: cover property (device_reset);
    c_vector: cover property (vector_after_wake);
    c_nop: cover property (sleep_as_nop);
endmodule // wdt_sleep_ctrl_monitor

bind wdt_sleep_ctrl wdt_sleep_ctrl_monitor i_mon (.clk, .rst_b, .clk_en,
    .sleep_op, .master_clear_pin, .global_irq_enable, .irq_enable_any,
    .irq_pending_any, .device_reset, .asleep, .osc_drive_en, .prefetch_next,
    .vector_after_wake, .sleep_as_nop, .master_clear_drive, .timeout_flag_n,
    .powerdown_flag_n, .pin_out, .pin_oe);

// File: verif/tb_watchdog_sleep_wake_control.sv
/* self-checking bench for wdt_sleep_ctrl: registers, expiry per postscale
   code, sleep entry and wake paths, fuse effects. assumes the header. */
`timescale 1ns/100ps
`include "wdt_sleep_defs.vh"
module tb_watchdog_sleep_wake_control;
    localparam int WDT = 8;
    logic clk = 0, rst_b = 0, rc_tick = 0, watchdog_clear_op = 0;
    logic sleep_op = 0, global_irq_enable = 0, wr = 0, rd = 0;
    logic irq_enable_any = 0, irq_pending_any = 0;
    logic rst_seen = 0, vec_seen = 0, ers_seen = 0;
    logic xtal_mode = 0, osc_tick = 0, master_clear_pin = 0;
    logic core_hold, prefetch_next;
    logic [7:0] pin_out_in = 0, pin_oe_in = 8'h5a, pin_out, pin_oe, pins;
    logic [13:0] prog_rdata_in = 14'h2a5, addr = 0, wdata = 0, rdata, rd_val;
    logic device_reset, asleep, osc_drive_en, vector_after_wake, sleep_as_nop;
    logic bulk_erase, master_clear_drive, timeout_flag_n, powerdown_flag_n;
    integer err_count = 0, check_count = 0, seed = 87, cyc = 0, ps, g;

    always #10 clk = ~clk;
    wdt_sleep_ctrl #(.WDT_CYCLES(WDT)) i_wdt_sleep_ctrl (.clk, .rst_b,
        .clk_en(1'b1), .rc_tick, .watchdog_clear_op, .sleep_op,
        .master_clear_pin, .global_irq_enable, .irq_enable_any,
        .irq_pending_any, .xtal_mode, .osc_tick, .pin_out_in,
        .pin_oe_in, .prog_rdata_in, .addr, .wdata, .wr, .rd, .rdata,
        .device_reset, .asleep, .osc_drive_en, .core_hold,
        .prefetch_next, .vector_after_wake, .sleep_as_nop, .bulk_erase,
        .pin_out, .pin_oe, .master_clear_drive, .timeout_flag_n,
        .powerdown_flag_n);

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (device_reset) rst_seen <= 1;
        if (vector_after_wake) vec_seen <= 1;
        if (bulk_erase) ers_seen <= 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            close_out();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk({13'h0, got}, {13'h0, exp});
    endtask
    task automatic wr_reg(input logic [13:0] a, input logic [13:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [13:0] a);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 rd_val = rdata;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            rc_tick <= 1;
            @(posedge clk);
            rc_tick <= 0;
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic pulse_op(input bit slp);
        @(posedge clk);
        if (slp) sleep_op <= 1;
        else watchdog_clear_op <= 1;
        @(posedge clk);
        sleep_op <= 0;
        watchdog_clear_op <= 0;
        #1 {rst_seen, vec_seen, ers_seen} = 3'b000;
    endtask
    task automatic wdt_run(input logic [7:0] opt, input int n);
        wr_reg(`OFS_OPTION, {6'h0, opt});
        pulse_op(0);
        ticks(n - 1);
        chk_b(rst_seen, 0);
        ticks(1);
        chk_b(rst_seen, 1);
        chk_b(timeout_flag_n, 0);
        repeat (4) @(posedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1;
        repeat (3) @(posedge clk);
        rd_reg(`OFS_OPTION);
        chk(rd_val, 14'h00ff);
        rd_reg(`OFS_STATUS);
        chk(rd_val & 14'h0018, 14'h0018);
        pins = $random(seed);
        wr_reg(`OFS_OPTION, {6'h0, pins});
        rd_reg(`OFS_OPTION);
        chk(rd_val, {6'h0, pins});
        wdt_run(8'hf7, WDT);
        for (ps = 0; ps < 8; ps++) wdt_run({5'h1f, ps[2:0]}, WDT << ps);
        for (g = 0; g < 2; g++) begin
            pins = $random(seed);
            @(posedge clk);
            pin_out_in <= pins;
            global_irq_enable <= g[0];
            pulse_op(1);
            pin_out_in <= ~pins;
            chk({asleep, powerdown_flag_n, osc_drive_en, prefetch_next},
                14'h9);
            repeat (3) @(posedge clk);
            #1 chk({6'h0, pin_out}, {6'h0, pins});
            irq_enable_any <= 1;
            irq_pending_any <= 1;
            repeat (10) @(posedge clk);
            irq_enable_any <= 0;
            irq_pending_any <= 0;
            #1 chk({asleep, vec_seen, rst_seen}, {12'h0, g[0], 1'b0});
        end
        wr_reg(`OFS_OPTION, 14'h00f7);
        pulse_op(0);
        pulse_op(1);
        ticks(WDT);
        chk({asleep, rst_seen, timeout_flag_n}, 14'h0);
        ticks(WDT - 1);
        chk_b(rst_seen, 0);
        @(posedge clk);
        global_irq_enable <= 0;
        irq_enable_any <= 1;
        irq_pending_any <= 1;
        pulse_op(1);
        chk({sleep_as_nop, asleep}, 14'h2);
        irq_enable_any <= 0;
        irq_pending_any <= 0;
        xtal_mode <= 1;
        osc_tick <= 1;
        pulse_op(1);
        irq_enable_any <= 1;
        irq_pending_any <= 1;
        repeat (1000) @(posedge clk);
        #1 chk({asleep, core_hold}, 14'h1);
        irq_enable_any <= 0;
        irq_pending_any <= 0;
        repeat (40) @(posedge clk);
        #1 chk({asleep, core_hold}, 14'h0);
        xtal_mode <= 0;
        osc_tick <= 0;
        pulse_op(1);
        master_clear_pin <= 1;
        @(posedge clk);
        master_clear_pin <= 0;
        repeat (2) @(posedge clk);
        #1 chk({asleep, rst_seen}, 14'h1);
        wr_reg(`OFS_PROGMODE, 14'h1);
        wr_reg(`OFS_FUSE, 14'h00fa);
        rd_reg(`OFS_FUSE);
        chk(rd_val, 14'h00fa);
        rd_reg(`OFS_PROG_DATA);
        chk(rd_val, 14'h0);
        wr_reg(`OFS_USERID0 + 14'h3, 14'h3c5a);
        rd_reg(`OFS_USERID0 + 14'h3);
        chk(rd_val, 14'h3c5a);
        pulse_op(0);
        ticks(2 * WDT);
        chk_b(rst_seen, 0);
        wr_reg(`OFS_ERASE, 14'h1);
        repeat (2) @(posedge clk);
        #1 chk_b(ers_seen, 1);
        rd_reg(`OFS_FUSE);
        chk(rd_val, 14'h00ff);
        rd_reg(`OFS_PROG_DATA);
        chk(rd_val, prog_rdata_in);
        wr_reg(`OFS_PROGMODE, 14'h0);
        rd_reg(`OFS_USERID0 + 14'h3);
        chk(rd_val, 14'h0);
        close_out();
    end
endmodule // tb_watchdog_sleep_wake_control
